//--- design/fast_counter_pkg.sv
// Purpose: Shared constants of the fast counter status and set-up block
// Assumes: APB byte addresses, 32-bit data, one word per register
// Notes: Counter n occupies a 32-byte window at n * CNT_STRIDE
package fast_counter_pkg;
  // Counter window layout
  localparam int NUM_CNT = 3;
  localparam logic [6:0] CNT_STRIDE = 7'h20;
  localparam logic [4:0] OFF_CTRL = 5'h00;   // counter control byte
  localparam logic [4:0] OFF_NEW_CV = 5'h04; // new current value
  localparam logic [4:0] OFF_NEW_PV = 5'h08; // new preset value
  localparam logic [4:0] OFF_STATUS = 5'h0c; // status byte, read only
  localparam logic [4:0] OFF_CV = 5'h10;     // current value, read only
  localparam logic [4:0] OFF_DEF = 5'h14;    // mode definition command
  localparam logic [4:0] OFF_UPD = 5'h18;    // update command
  localparam logic [4:0] OFF_PV = 5'h1c;     // preset value, read only
  // Global registers
  localparam logic [6:0] ADR_IRQ_STATUS = 7'h60;
  localparam logic [6:0] ADR_IRQ_MASK = 7'h64;
  localparam logic [6:0] ADR_GIE = 7'h68;
  localparam logic [6:0] ADR_ERR = 7'h6c;
  localparam logic [6:0] ADR_LAST_EVT = 7'h70;
  // Control byte fields
  localparam int CB_RST_LOW = 0;
  localparam int CB_START_LOW = 1;
  localparam int CB_DIR = 3;
  localparam int CB_LD_DIR = 4;
  localparam int CB_LD_PV = 5;
  localparam int CB_LD_CV = 6;
  localparam int CB_ENABLE = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_FULL_SETUP = 8'hf8;
  // Status byte fields
  localparam int SB_DIR = 5;
  localparam int SB_EQ = 6;
  localparam int SB_GT = 7;
  // Modes
  localparam logic [3:0] MODE_MAX = 4'h8;
  localparam logic [3:0] MODE_EXT_DIR = 4'h3;
  localparam logic [3:0] MODE_TWO_CLK = 4'h6;
  // Interrupt event numbers
  localparam logic [7:0] EVT_EQ = 8'h0d;
  localparam logic [7:0] EVT_DIR = 8'h0e;
  localparam logic [7:0] EVT_RST = 8'h0f;
  // Sticky status bit layout: three bits per counter
  localparam int IRQ_W = 9;
  localparam int IB_EQ = 0;
  localparam int IB_DIR = 1;
  localparam int IB_RST = 2;
  // Error codes
  localparam logic [1:0] ERR_TWICE = 2'h1;
  localparam logic [1:0] ERR_BAD_MODE = 2'h2;
endpackage : fast_counter_pkg

//--- design/fast_counter_status_irq_setup.sv
// Purpose: Status, interrupt and set-up logic of three fast counters
// Assumes: APB slave on pclk; run_mode comes from logic on pclk
// Notes: Pins pass a three-stage filter before use
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RQ1] Status bit 5 shows the counting direction, 1 up, 0 down.
// [RQ2] Status bit 6 is 1 while current value equals preset.
// [RQ3] Status bit 7 is 1 when current exceeds preset; bits 0-4 zero.
// [RQ4] Software trusts status bytes only inside the interrupt routine.
// [RQ5] Counter zero raises only the equal-to-preset interrupt.
// [RQ6] Counters one and two: equal, reset, direction events, each maskable.
// [RQ7] Definition accepted once per run; a repeat flags error, keeps setup.
// [RQ8] Modes 0-2: internal direction; none, reset, reset plus start.
// [RQ9] Modes 3-5: external direction input; none, reset, reset plus start.
// [RQ10] Modes 6-8: separate up and down clocks; none, reset, both.
// [RQ11] Events are numbered 13 equal, 14 direction, 15 reset.
// [RQ12] Control value f8 enables, loads both values, counts up, active high.
// [RQ13] Order: control, define, values, attach events, enable, then update.
// [RQ14] Software initialises once from a first-scan subroutine.
// [RQ15] Update: bit3 direction, bits 4-6 load gates, bit7 enable.
// [RQ16] Reset clears and holds; inactive start holds count, ignores reset.
// [RQ17] Current and preset values are 32-bit signed, compared signed.
// [RQ18] Equal and direction events fire once on entry into the condition.
module fast_counter_status_irq_setup
  import fast_counter_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic run_mode,
  input wire logic [2:0] count_pin_a,
  input wire logic [2:0] count_pin_b,
  input wire logic [2:0] count_pin_reset,
  input wire logic [2:0] count_pin_start,
  output logic irq
);
  // Register state
  logic [7:0] ctrl [NUM_CNT];
  logic [31:0] new_cv [NUM_CNT];
  logic [31:0] new_pv [NUM_CNT];
  logic [3:0] mode [NUM_CNT];
  logic [NUM_CNT-1:0] defined;
  logic [NUM_CNT-1:0] rst_low;
  logic [NUM_CNT-1:0] start_low;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic gie;
  logic [1:0] err_code;
  logic err_flag;
  logic [1:0] err_cnt;
  logic [7:0] last_evt;
  logic [1:0] last_evt_cnt;

  // Bus decode
  logic wr_en, rd_setup, hit;
  logic [1:0] sel_cnt;
  logic [4:0] sel_off;
  logic [NUM_CNT-1:0] upd_pulse;
  logic [NUM_CNT-1:0] def_pulse;

  // Filtered pins
  logic [11:0] pin_raw;
  logic [11:0] pin_s1, pin_s2, pin_s3, pin_lvl;

  // Counter outputs
  logic signed [31:0] cur [NUM_CNT];
  logic signed [31:0] pre [NUM_CNT];
  logic [NUM_CNT-1:0] dir_up, cnt_en, ev_eq, ev_dir, ev_rst;
  logic [7:0] status_byte [NUM_CNT];
  logic [IRQ_W-1:0] irq_set;

  // Counter index of an address inside the counter windows
  function automatic logic [1:0] cnt_of(input logic [31:0] a);
    cnt_of = a[6:5];
  endfunction : cnt_of

  // True when the address is a mapped register
  function automatic logic is_mapped(input logic [31:0] a);
    logic ok;
    ok = 1'b0;
    if (a[31:7] == 25'h0 && a[1:0] == 2'h0) begin
      if (a[6:5] < 2'(NUM_CNT)) begin
        ok = 1'b1;
      end else begin
        ok = (a[6:0] <= ADR_LAST_EVT);
      end
    end
    is_mapped = ok;
  endfunction : is_mapped

  // Address split into counter window and offset inside it
  assign sel_cnt = cnt_of(paddr);
  assign sel_off = paddr[4:0];
  assign hit = is_mapped(paddr);
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_setup = psel && !penable && !pwrite;
  // Zero-wait slave; unmapped addresses answer with an error
  // Unmapped writes change nothing and reads of them give zero
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Command pulses per counter
  // Update is a write whose data is not stored; definition keeps data bits 3:0 as the mode
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++) begin : g_cmd
      assign upd_pulse[gi] = wr_en && sel_cnt == 2'(gi) && sel_off == OFF_UPD;
      assign def_pulse[gi] = wr_en && sel_cnt == 2'(gi) && sel_off == OFF_DEF;
    end
  endgenerate

  // Pin filter: three flops, a change counts when stages two and three agree
  // Stage one may be metastable, so nothing else reads it
  assign pin_raw = {count_pin_start, count_pin_reset, count_pin_b,
                    count_pin_a};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Level per pin, moved only by two agreeing samples
  generate
    for (gi = 0; gi < 12; gi++) begin : g_filt
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_lvl[gi] <= 1'b0;
        end else if (pin_s2[gi] == pin_s3[gi]) begin
          pin_lvl[gi] <= pin_s3[gi];
        end
      end
    end
  endgenerate

  // Software-written control bytes and holding words
  // Holding words act only at the next update command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        ctrl[i] <= CTRL_RESET;
        new_cv[i] <= '0;
        new_pv[i] <= '0;
      end
    end else if (wr_en && sel_cnt < 2'(NUM_CNT)) begin
      unique case (sel_off)
        OFF_CTRL: ctrl[sel_cnt] <= pwdata[7:0];
        OFF_NEW_CV: new_cv[sel_cnt] <= pwdata;
        OFF_NEW_PV: new_pv[sel_cnt] <= pwdata;
        default: ;
      endcase
    end
  end

  // Mode definition: once per counter while in run mode
  // Reset and start polarity are latched here only
  // Counter zero has no polarity bits, its pins stay active high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      defined <= '0;
      rst_low <= '0;
      start_low <= '0;
      for (int i = 0; i < NUM_CNT; i++) begin
        mode[i] <= '0;
      end
    end else if (!run_mode) begin
      defined <= '0; // Stop frees every counter for a new definition
    end else begin
      for (int i = 0; i < NUM_CNT; i++) begin
        if (def_pulse[i] && !defined[i] && pwdata[3:0] <= MODE_MAX
            && pwdata[31:4] == 28'h0) begin
          defined[i] <= 1'b1; // RQ7
          mode[i] <= pwdata[3:0]; // RQ8 RQ9 RQ10
          rst_low[i] <= (i != 0) && ctrl[i][CB_RST_LOW];
          start_low[i] <= (i != 0) && ctrl[i][CB_START_LOW];
        end
      end
    end
  end

  // Run-time error: repeated or illegal definition, setup left as it was
  // A new error beats a clear of the flag in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_flag <= 1'b0;
      err_code <= '0;
      err_cnt <= '0;
    end else if (|def_pulse && run_mode
                 && defined[sel_cnt]) begin
      err_flag <= 1'b1; // RQ7
      err_code <= ERR_TWICE;
      err_cnt <= sel_cnt;
    end else if (|def_pulse && run_mode
                 && (pwdata[3:0] > MODE_MAX || pwdata[31:4] != 28'h0)) begin
      err_flag <= 1'b1;
      err_code <= ERR_BAD_MODE;
      err_cnt <= sel_cnt;
    end else if (wr_en && paddr[6:0] == ADR_ERR && pwdata[0]) begin
      err_flag <= 1'b0;
    end
  end

  // The counters
  // Reset and start reach each counter already active high
  generate
    for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
      fast_counter_unit u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .defined(defined[gi]),
        .mode(mode[gi]),
        .upd(upd_pulse[gi] && run_mode),
        .ctrl(ctrl[gi]),
        .new_cv(new_cv[gi]),
        .new_pv(new_pv[gi]),
        .pin_a(pin_lvl[gi]),
        .pin_b(pin_lvl[3 + gi]),
        .pin_rst(pin_lvl[6 + gi] ^ rst_low[gi]),
        .pin_start(pin_lvl[9 + gi] ^ start_low[gi]),
        .current_value(cur[gi]),
        .preset_value(pre[gi]),
        .dir_up(dir_up[gi]),
        .enabled(cnt_en[gi]),
        .ev_eq(ev_eq[gi]),
        .ev_dir(ev_dir[gi]),
        .ev_rst(ev_rst[gi])
      );
      // Status byte: direction, equal, greater, low bits unused
      // Greater and equal use the signed values
      assign status_byte[gi] = {cur[gi] > pre[gi], // RQ3 RQ17
                                cur[gi] == pre[gi], // RQ2
                                dir_up[gi], // RQ1
                                5'h00}; // RQ3
      // Counter zero has the equal event only
      assign irq_set[3*gi + IB_EQ] = ev_eq[gi]; // RQ5 RQ6
      assign irq_set[3*gi + IB_DIR] = (gi != 0) && ev_dir[gi]; // RQ5 RQ6
      assign irq_set[3*gi + IB_RST] = (gi != 0) && ev_rst[gi]; // RQ5 RQ6
    end
  endgenerate

  // Sticky interrupt status, write one to clear, a new event wins
  // so an event in the cycle of its own clear is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else if (wr_en && paddr[6:0] == ADR_IRQ_STATUS) begin
      irq_status <= (irq_status & ~pwdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  // Mask and global enable
  // Mask bits line up with the sticky status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= '0;
      gie <= 1'b0;
    end else if (wr_en) begin
      if (paddr[6:0] == ADR_IRQ_MASK) begin
        irq_mask <= pwdata[IRQ_W-1:0]; // RQ6
      end
      if (paddr[6:0] == ADR_GIE) begin
        gie <= pwdata[0];
      end
    end
  end

  // Number of the latest event, lowest counter first
  // The loop runs downward, so counter zero is written last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_evt <= '0;
      last_evt_cnt <= '0;
    end else begin
      for (int i = NUM_CNT - 1; i >= 0; i--) begin
        if (irq_set[3*i + IB_EQ]) begin
          last_evt <= EVT_EQ; // RQ11
          last_evt_cnt <= 2'(i);
        end else if (irq_set[3*i + IB_DIR]) begin
          last_evt <= EVT_DIR; // RQ11
          last_evt_cnt <= 2'(i);
        end else if (irq_set[3*i + IB_RST]) begin
          last_evt <= EVT_RST; // RQ11
          last_evt_cnt <= 2'(i);
        end
      end
    end
  end

  // Level interrupt: an unmasked sticky bit while globally enabled
  logic [IRQ_W-1:0] pending;
  assign pending = irq_status & irq_mask; // RQ6
  assign irq = gie && |pending;

  // Read data captured in the setup phase, shown in the access phase
  // Taken from a register, so prdata stands for the whole access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= '0;
      if (!hit) begin
        prdata <= '0;
      end else if (sel_cnt < 2'(NUM_CNT)) begin
        unique case (sel_off)
          OFF_CTRL: prdata <= {24'h0, ctrl[sel_cnt]};
          OFF_NEW_CV: prdata <= new_cv[sel_cnt];
          OFF_NEW_PV: prdata <= new_pv[sel_cnt];
          OFF_STATUS: prdata <= {24'h0, status_byte[sel_cnt]};
          OFF_CV: prdata <= cur[sel_cnt];
          OFF_DEF: prdata <= {26'h0, cnt_en[sel_cnt], defined[sel_cnt],
                              mode[sel_cnt]};
          OFF_PV: prdata <= pre[sel_cnt];
          default: prdata <= '0;
        endcase
      end else begin
        unique case (paddr[6:0])
          ADR_IRQ_STATUS: prdata <= {23'h0, irq_status};
          ADR_IRQ_MASK: prdata <= {23'h0, irq_mask};
          ADR_GIE: prdata <= {31'h0, gie};
          ADR_ERR: prdata <= {27'h0, err_cnt, err_code, err_flag};
          ADR_LAST_EVT: prdata <= {22'h0, last_evt_cnt, last_evt};
          default: prdata <= '0;
        endcase
      end
    end
  end
endmodule : fast_counter_status_irq_setup
`default_nettype wire

//--- design/fast_counter_unit.sv
// Purpose: One fast counter: current and preset values, direction, events
// Assumes: Filtered, polarity-corrected pin levels on pclk
// Notes: Events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module fast_counter_unit
  import fast_counter_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic defined,
  input wire logic [3:0] mode,
  input wire logic upd,
  input wire logic [7:0] ctrl,
  input wire logic [31:0] new_cv,
  input wire logic [31:0] new_pv,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic pin_rst,
  input wire logic pin_start,
  output logic signed [31:0] current_value,
  output logic signed [31:0] preset_value,
  output logic dir_up,
  output logic enabled,
  output logic ev_eq,
  output logic ev_dir,
  output logic ev_rst
);
  logic a_q, b_q, rst_eff_q, eq_q, dir_q;
  logic a_rise, b_rise, use_rst, use_start, rst_eff, gated, cnt_up, cnt_dn;
  logic [1:0] sub;
  logic eq_now;

  // Mode decode: low digit of mode selects reset and start use
  always_comb begin
    sub = 2'(mode % 4'h3);
    use_rst = defined && (sub != 2'h0); // RQ8 RQ9 RQ10
    use_start = defined && (sub == 2'h2);
    gated = use_start && !pin_start;
    rst_eff = use_rst && pin_rst && !gated; // RQ16
    a_rise = pin_a && !a_q;
    b_rise = pin_b && !b_q;
    cnt_up = 1'b0;
    cnt_dn = 1'b0;
    if (enabled && defined && !gated && !rst_eff) begin
      if (mode >= MODE_TWO_CLK) begin
        cnt_up = a_rise; // RQ10
        cnt_dn = b_rise;
      end else begin
        cnt_up = a_rise && dir_up; // RQ8 RQ9
        cnt_dn = a_rise && !dir_up;
      end
    end
  end

  // Edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      rst_eff_q <= 1'b0;
    end else begin
      a_q <= pin_a;
      b_q <= pin_b;
      rst_eff_q <= rst_eff;
    end
  end

  // Current value: update load, external reset, counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_value <= '0;
    end else if (upd && ctrl[CB_LD_CV]) begin
      current_value <= new_cv; // RQ15
    end else if (rst_eff) begin
      current_value <= '0; // RQ16
    end else if (cnt_up) begin
      current_value <= current_value + 32'sh1;
    end else if (cnt_dn) begin
      current_value <= current_value - 32'sh1;
    end
  end

  // Preset value and enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_value <= '0;
      enabled <= 1'b0;
    end else begin
      if (upd && ctrl[CB_LD_PV]) begin
        preset_value <= new_pv; // RQ15
      end
      if (!defined) begin
        enabled <= 1'b0;
      end else if (upd) begin
        enabled <= ctrl[CB_ENABLE]; // RQ12 RQ15
      end
    end
  end

  // Direction: internal control, external level, or last clock seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_up <= 1'b1;
    end else if (upd && ctrl[CB_LD_DIR]) begin
      dir_up <= ctrl[CB_DIR]; // RQ15
    end else if (defined && mode >= MODE_EXT_DIR && mode < MODE_TWO_CLK) begin
      dir_up <= pin_b; // RQ9
    end else if (cnt_up) begin
      dir_up <= 1'b1;
    end else if (cnt_dn) begin
      dir_up <= 1'b0;
    end
  end

  // Event edges: raised once per entry into the condition
  assign eq_now = (current_value == preset_value);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_q <= 1'b0;
      dir_q <= 1'b1;
    end else begin
      eq_q <= eq_now;
      dir_q <= dir_up;
    end
  end

  assign ev_eq = enabled && eq_now && !eq_q; // RQ18
  assign ev_dir = enabled && (dir_up != dir_q); // RQ18
  assign ev_rst = rst_eff && !rst_eff_q;
endmodule : fast_counter_unit
`default_nettype wire

//--- tb/count_pulse_source.sv
// Purpose: External pulse sources with reset and start inputs
// Assumes: Pins are sampled through the design's input filter
// Notes: Each level is held long enough to pass the filter
`timescale 1ns/1ps
`default_nettype none
module count_pulse_source (
  input wire logic pclk,
  output logic [2:0] pin_a,
  output logic [2:0] pin_b,
  output logic [2:0] pin_reset,
  output logic [2:0] pin_start
);
  logic [11:0] pins = 12'h0;
  // Pins grouped by kind, three counters each
  assign pin_a = pins[2:0];
  assign pin_b = pins[5:3];
  assign pin_reset = pins[8:6];
  assign pin_start = pins[11:9];
  // One pulse on kind k of counter c, each level held len cycles
  task pulse(input int c, input int k, input int len);
    @(posedge pclk);
    pins[k * 3 + c] <= 1'b1;
    repeat (len) @(posedge pclk);
    pins[k * 3 + c] <= 1'b0;
    repeat (len) @(posedge pclk);
  endtask : pulse
  // Start level of counter c, given time to settle
  task set_start(input int c, input logic v);
    @(posedge pclk);
    pins[9 + c] <= v;
    repeat (8) @(posedge pclk);
  endtask : set_start
endmodule : count_pulse_source
`default_nettype wire

//--- tb/fast_counter_monitor.sv
// Purpose: Port-level checks of the fast counter status and set-up block
// Assumes: Zero-wait APB slave, registers at the package offsets
// Notes: Shadows of mask and global enable follow completed APB writes
`timescale 1ns/1ps
`default_nettype none
module fast_counter_monitor
  import fast_counter_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic run_mode,
  input wire logic [2:0] count_pin_a,
  input wire logic [2:0] count_pin_b,
  input wire logic [2:0] count_pin_reset,
  input wire logic [2:0] count_pin_start,
  input wire logic irq
);
  logic acc;
  logic rd;
  logic st;
  logic df;
  logic gie_sh;
  logic [8:0] mask_sh;
  // Decode of completed accesses inside the register map
  assign acc = psel && penable && pready && paddr[31:7] == 25'h0;
  assign rd = acc && !pwrite;
  assign st = rd && paddr[4:0] == OFF_STATUS && paddr[6:5] != 2'h3;
  assign df = rd && paddr[4:0] == OFF_DEF && paddr[6:5] != 2'h3;
  // Shadow copies of the interrupt gates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_sh <= 1'b0;
      mask_sh <= 9'h0;
    end else if (acc && pwrite) begin
      if (paddr[6:0] == ADR_GIE) gie_sh <= pwdata[0];
      if (paddr[6:0] == ADR_IRQ_MASK) mask_sh <= pwdata[8:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup cycle followed by the access of a read at one address
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read(logic [6:0] a);
    s_setup ##1 rd && paddr[6:0] == a;
  endsequence
  a_status_unused: assert property (s_setup ##1 st |->
    prdata[4:0] == 5'h0 && prdata[31:8] == 24'h0)
    else $error("status byte unused bits set");
  a_eq_gt_excl: assert property (st |->
    !(prdata[SB_EQ] && prdata[SB_GT]))
    else $error("equal and greater both set");
  a_zero_one_source: assert property (s_read(ADR_IRQ_STATUS) |->
    prdata[2:1] == 2'h0 && prdata[31:9] == 23'h0)
    else $error("counter zero raised a second source");
  a_event_number: assert property (s_read(ADR_LAST_EVT) |->
    prdata[7:0] inside {8'h0, EVT_EQ, EVT_DIR, EVT_RST})
    else $error("event number out of set");
  a_mode_range: assert property (df |-> prdata[3:0] <= MODE_MAX)
    else $error("defined mode out of range");
  a_gie_gate: assert property (!gie_sh |-> !irq)
    else $error("interrupt while globally disabled");
  a_mask_gate: assert property (mask_sh == 9'h0 |-> !irq)
    else $error("interrupt while all sources masked");
  a_unmapped_err: assert property (psel && penable &&
    paddr[6:0] > ADR_LAST_EVT |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_ready_high: assert property (psel |-> pready)
    else $error("ready low during transfer");
endmodule : fast_counter_monitor
bind fast_counter_status_irq_setup fast_counter_monitor
  i_fast_counter_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .run_mode(run_mode),
  .count_pin_a(count_pin_a), .count_pin_b(count_pin_b),
  .count_pin_reset(count_pin_reset), .count_pin_start(count_pin_start),
  .irq(irq));
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench of the fast counter status and set-up block
// Assumes: Zero-wait APB slave, counter windows 0x20 apart
// Notes: Reads queue their expectation; a watcher compares on completion
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import fast_counter_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic run_mode = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [2:0] pa;
  logic [2:0] pb;
  logic [2:0] prst;
  logic [2:0] pst;
  logic [31:0] exp_q[$];
  int n_errors = 0;
  int n_compared = 0;
  integer seed = 32'h38c8;
  logic [31:0] rv;
  int m;
  // Clock of 100 ns period
  always #50 pclk = ~pclk;
  fast_counter_status_irq_setup i_fast_counter_status_irq_setup (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run_mode(run_mode),
    .count_pin_a(pa), .count_pin_b(pb), .count_pin_reset(prst),
    .count_pin_start(pst), .irq(irq));
  count_pulse_source i_count_pulse_source (.pclk(pclk), .pin_a(pa),
    .pin_b(pb), .pin_reset(prst), .pin_start(pst));
  // Comparison of one seen value against its expectation
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task final_report;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  // One APB transfer, held until ready is seen high
  task xfer(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {25'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task wr(input logic [6:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task rd(input logic [6:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  // Interrupt line looked at once the write edge has settled
  task chk_irq(input logic exp);
    @(negedge pclk);
    check({31'h0, irq}, {31'h0, exp});
  endtask : chk_irq
  // Count pulses with random level lengths, prompt to slow
  task pul(input int c, input int k, input int cnt);
    repeat (cnt) i_count_pulse_source.pulse(c, k,
      5 + $unsigned($random(seed)) % 8);
  endtask : pul
  // Completed reads are compared with the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      check(prdata, exp_q.pop_front());
    end
  end
  // Hang guard
  initial begin
    #(20000 * 100);
    n_errors++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    run_mode <= 1'b1;
    rd(7'h0c, 32'h60);
    rd(ADR_IRQ_STATUS, 32'h0);
    // Counter one set up in order, every event unmasked
    wr(7'h20, CTRL_FULL_SETUP);
    wr(7'h34, 32'h0);
    wr(7'h24, 32'h0);
    wr(7'h28, 32'h3);
    wr(ADR_IRQ_MASK, 32'h1ff);
    wr(ADR_GIE, 32'h1);
    wr(7'h38, 32'h0);
    rd(7'h2c, 32'h20);
    pul(1, 0, 3);
    rd(7'h2c, 32'h60);
    rd(7'h30, 32'h3);
    rd(ADR_IRQ_STATUS, 32'h8);
    rd(ADR_LAST_EVT, 32'h10d);
    chk_irq(1'b1);
    wr(ADR_IRQ_STATUS, 32'h8);
    chk_irq(1'b0);
    repeat (10) @(posedge pclk);
    rd(ADR_IRQ_STATUS, 32'h0);
    pul(1, 0, 1);
    rd(7'h2c, 32'ha0);
    // Direction turned down by an update
    wr(7'h20, 32'h90);
    wr(7'h38, 32'h0);
    rd(7'h2c, 32'h80);
    rd(ADR_IRQ_STATUS, 32'h10);
    wr(ADR_IRQ_STATUS, 32'h10);
    pul(1, 0, 1);
    rd(7'h2c, 32'h40);
    rd(ADR_IRQ_STATUS, 32'h8);
    // A second definition is refused and the first one stands
    wr(7'h34, 32'h5);
    rd(ADR_ERR, 32'hb);
    rd(7'h34, 32'h30);
    // Counter zero loaded with random values
    rv = $random(seed);
    wr(7'h14, 32'h0);
    wr(7'h04, rv);
    wr(7'h08, rv + 32'h1);
    wr(7'h00, 32'he0);
    wr(7'h18, 32'h0);
    rd(7'h10, rv);
    rd(7'h1c, rv + 32'h1);
    rd(7'h0c, ($signed(rv) < $signed(rv + 32'h1)) ? 32'h20 : 32'ha0);
    // Bad mode, then every mode, freed each time by a stop
    wr(ADR_ERR, 32'h1);
    wr(7'h54, 32'h9);
    rd(ADR_ERR, 32'h15);
    for (m = 0; m < 9; m++) begin
      @(posedge pclk);
      run_mode <= 1'b0;
      @(posedge pclk);
      run_mode <= 1'b1;
      wr(7'h54, 32'(m));
      rd(7'h54, 32'h10 + 32'(m));
    end
    // Counter two in mode 8: start gates reset and clocks
    wr(7'h40, CTRL_FULL_SETUP);
    wr(7'h44, 32'h5);
    wr(7'h48, 32'h64);
    wr(7'h58, 32'h0);
    pul(2, 2, 1);
    pul(2, 0, 1);
    rd(7'h50, 32'h5);
    wr(ADR_IRQ_STATUS, 32'h1ff);
    i_count_pulse_source.set_start(2, 1'b1);
    pul(2, 2, 1);
    rd(7'h50, 32'h0);
    rd(ADR_LAST_EVT, 32'h20f);
    pul(2, 1, 1);
    rd(7'h50, 32'hffffffff);
    rd(7'h4c, 32'h0);
    rd(ADR_IRQ_STATUS, 32'h180);
    // Mask and global enable gate the line
    chk_irq(1'b1);
    wr(ADR_IRQ_MASK, 32'h0);
    chk_irq(1'b0);
    wr(ADR_IRQ_MASK, 32'h80);
    chk_irq(1'b1);
    wr(ADR_GIE, 32'h0);
    chk_irq(1'b0);
    rd(7'h74, 32'h0);
    repeat (4) @(posedge pclk);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
